// ==== rtl/afsr_regs.sv ====
`timescale 1ns/1ps
module afsr_regs (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire afsr_pkg::afsr_glob_evt_t i_glob,
  input wire afsr_pkg::afsr_chan_evt_t i_chan,
  input wire afsr_pkg::afsr_chan_state_t i_state,
  input wire logic i_fault_clear,
  input wire logic i_sub_load,
  input wire logic [7:0] i_sub_addr,
  input wire logic i_wr_byte,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_byte,
  output logic [7:0] o_rd_data,
  output logic [7:0] o_sub_addr,
  output afsr_pkg::afsr_ctrl_t o_ctrl
);
  import afsr_pkg::*;

  logic rst_meta;
  logic rst_n;
  logic [7:0] sub_addr;
  logic [7:0] next_rd_data;
  logic [7:0] set_glob;
  logic [7:0] set_chan;
  logic [7:0] set_d12;
  logic [7:0] set_d34;
  logic [7:0] q_glob;
  logic [7:0] q_chan;
  logic [7:0] q_d12;
  logic [7:0] q_d34;
  logic [7:0] live_temp;
  logic [7:0] live_out;
  logic [7:0] live_mute;
  logic [7:0] live_act;
  logic [7:0] live_therm;
  logic [3:0] lowlow;
  logic [8:0] glob_s2;
  logic [8:0] glob_s3;
  logic [23:0] chan_s2;
  logic [23:0] chan_s3;
  logic [27:0] st_s2;
  logic [27:0] st_s3;
  logic [23:0] chan_sync;
  logic [27:0] st_sync;
  logic [8:0] glob_sync;
  logic [8:0] glob_m;
  logic [23:0] chan_m;
  logic [27:0] st_m;
  afsr_glob_evt_t g;
  afsr_chan_evt_t c;
  afsr_chan_state_t s;
  // control register flops, gathered into o_ctrl below
  logic [7:0] ctrl_gain;
  logic [7:0] ctrl_oc;
  logic [7:0] ctrl_swfreq;
  logic [7:0] ctrl_diag;
  logic [7:0] ctrl_out_a;
  logic [7:0] ctrl_out_b;
  logic [7:0] ctrl_thresh;
  logic wr_ok;

  // reset release through two flops
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // fault and state inputs come from analog detectors, so three flops
  // and a change counts once the last two agree
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      glob_m <= 9'h000;
      glob_s2 <= 9'h000;
      glob_s3 <= 9'h000;
    end else begin
      glob_m <= i_glob;
      glob_s2 <= glob_m;
      glob_s3 <= glob_s2;
    end
  end

  // channel events, same three-stage treatment
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      chan_m <= 24'h000000;
      chan_s2 <= 24'h000000;
      chan_s3 <= 24'h000000;
    end else begin
      chan_m <= i_chan;
      chan_s2 <= chan_m;
      chan_s3 <= chan_s2;
    end
  end

  // the state pipeline resets to high impedance too, so the agreed value
  // cannot drop out of high impedance for a few cycles after reset
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_m <= {8'h00, RST_OUT_STATE[3:0], 16'h0000};
      st_s2 <= {8'h00, RST_OUT_STATE[3:0], 16'h0000};
      st_s3 <= {8'h00, RST_OUT_STATE[3:0], 16'h0000};
    end else begin
      st_m <= i_state;
      st_s2 <= st_m;
      st_s3 <= st_s2;
    end
  end

  // hold the last agreed value while the two stages disagree
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      glob_sync <= 9'h000;
    end else begin
      glob_sync <= (glob_s2 & glob_s3) | (glob_sync & (glob_s2 | glob_s3));
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      chan_sync <= 24'h000000;
    end else begin
      chan_sync <= (chan_s2 & chan_s3) | (chan_sync & (chan_s2 | chan_s3));
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_sync <= {8'h00, RST_OUT_STATE[3:0], 16'h0000};
    end else begin
      st_sync <= (st_s2 & st_s3) | (st_sync & (st_s2 | st_s3));
    end
  end

  assign g = afsr_glob_evt_t'(glob_sync);
  assign c = afsr_chan_evt_t'(chan_sync);
  assign s = afsr_chan_state_t'(st_sync);

  always_comb begin
    set_glob = 8'h00;
    set_glob[BIT_PV_OV] = g.power_rail_overvolt;
    set_glob[BIT_PV_UV] = g.power_rail_undervolt;
    set_glob[BIT_AN_UV] = g.analog_rail_undervolt;
    set_glob[BIT_CHARGE_PUMP_UNDERVOLT_LATCHED] = g.charge_pump_undervolt;
    set_glob[BIT_OT_SD] = g.overtemp_shutdown;
    set_glob[BIT_ANY_OC] = |c.overcurrent;
    set_glob[BIT_ANY_DC] = |c.dc_offset;
    set_glob[BIT_OT_WARN] = g.overtemp_warning;
  end

  assign set_chan = {c.dc_offset, c.overcurrent};

  // the events come in as an argument so the continuous assigns below
  // re-evaluate whenever any channel event changes
  function automatic logic [3:0] diag_nib(input afsr_chan_evt_t ce,
                                          input logic [1:0] ch);
    diag_nib = {ce.open_load[ch], ce.shorted_load[ch],
                ce.short_to_supply[ch], ce.short_to_ground[ch]};
  endfunction : diag_nib

  assign set_d12 = {diag_nib(c, 2'h1), diag_nib(c, 2'h0)};
  assign set_d34 = {diag_nib(c, 2'h3), diag_nib(c, 2'h2)};

  // latched banks; clear only by the device's fault clear pulse
  // a set in the clearing cycle survives, so no event is lost
  afsr_latch8 u_glob (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_set(set_glob),
    .i_clear(i_fault_clear),
    .o_q(q_glob)
  );
  afsr_latch8 u_chan (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_set(set_chan),
    .i_clear(i_fault_clear),
    .o_q(q_chan)
  );
  afsr_latch8 u_d12 (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_set(set_d12),
    .i_clear(i_fault_clear),
    .o_q(q_d12)
  );
  afsr_latch8 u_d34 (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_set(set_d34),
    .i_clear(i_fault_clear),
    .o_q(q_d34)
  );

  // illegal grade codes from the detector read as none
  function automatic logic [2:0] grade_fix(input logic [2:0] gr);
    case (gr)
      GRADE_WARN, GRADE_L1, GRADE_L2, GRADE_L3: grade_fix = gr;
      default: grade_fix = GRADE_NONE;
    endcase
  endfunction : grade_fix

  assign live_temp = {grade_fix(g.overtemp_warn_grade),
                      g.overtemp_shutdown, g.charge_pump_undervolt,
                      g.analog_rail_undervolt, g.power_rail_undervolt,
                      g.power_rail_overvolt};
  assign lowlow = s.out_p_low & s.out_n_low & ~s.hiz;
  assign live_out = {lowlow, s.hiz};
  assign live_mute = {s.mute, s.play};
  assign live_act = {s.foldback, s.diag_mode};
  assign live_therm = {3'h0, g.overtemp_shutdown, s.foldback};

  // subaddress pointer
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      sub_addr <= 8'h00;
    end else if (i_sub_load) begin
      sub_addr <= i_sub_addr;
    end else if (i_wr_byte || i_rd_byte) begin
      sub_addr <= sub_addr + 8'h01;
    end
  end

  // one flop per register; writes elsewhere are dropped
  assign wr_ok = i_wr_byte && !i_sub_load;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_gain <= RST_GAIN;
    end else if (wr_ok && sub_addr == ADDR_GAIN) begin
      ctrl_gain <= i_wr_data;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_oc <= RST_OC_CTRL;
    end else if (wr_ok && sub_addr == ADDR_OC_CTRL) begin
      ctrl_oc <= i_wr_data;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_swfreq <= RST_CTRL;
    end else if (wr_ok && sub_addr == ADDR_SWFREQ) begin
      ctrl_swfreq <= i_wr_data;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_diag <= RST_CTRL;
    end else if (wr_ok && sub_addr == ADDR_DIAG_MASTER) begin
      ctrl_diag <= i_wr_data;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_out_a <= RST_CTRL;
    end else if (wr_ok && sub_addr == ADDR_OUT_CTRL_A) begin
      ctrl_out_a <= i_wr_data;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_out_b <= RST_CTRL;
    end else if (wr_ok && sub_addr == ADDR_OUT_CTRL_B) begin
      ctrl_out_b <= i_wr_data;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_thresh <= RST_CTRL;
    end else if (wr_ok && sub_addr == ADDR_DC_THRESH) begin
      ctrl_thresh <= i_wr_data;
    end
  end

  // fields packed in the order of the control struct
  assign o_ctrl = {ctrl_gain, ctrl_oc, ctrl_swfreq, ctrl_diag,
                   ctrl_out_a, ctrl_out_b, ctrl_thresh};

  always_comb begin
    case (sub_addr)
      ADDR_GLOBAL_FAULT: next_rd_data = q_glob;
      ADDR_CHAN_FAULT: next_rd_data = q_chan;
      ADDR_DIAG_CH12: next_rd_data = q_d12;
      ADDR_DIAG_CH34: next_rd_data = q_d34;
      ADDR_TEMP_SUPPLY: next_rd_data = live_temp;
      ADDR_OUT_STATE: next_rd_data = live_out;
      ADDR_MUTE_PLAY: next_rd_data = live_mute;
      ADDR_DIAG_ACT: next_rd_data = live_act;
      ADDR_GAIN: next_rd_data = o_ctrl.gain;
      ADDR_OC_CTRL: next_rd_data = o_ctrl.oc_ctrl;
      ADDR_SWFREQ: next_rd_data = o_ctrl.swfreq;
      ADDR_DIAG_MASTER: next_rd_data = o_ctrl.diag_master;
      ADDR_OUT_CTRL_A: next_rd_data = o_ctrl.out_ctrl_a;
      ADDR_OUT_CTRL_B: next_rd_data = o_ctrl.out_ctrl_b;
      ADDR_DC_THRESH: next_rd_data = o_ctrl.dc_thresh;
      ADDR_THERM_SD: next_rd_data = live_therm;
      default: next_rd_data = 8'h00;
    endcase
  end

  // read data registered so the serial engine sees a stable byte
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= next_rd_data;
    end
  end

  assign o_sub_addr = sub_addr;
endmodule : afsr_regs

// ==== rtl/afsr_pkg.sv ====
package afsr_pkg;
  localparam logic [7:0] ADDR_GLOBAL_FAULT = 8'h00;
  localparam logic [7:0] ADDR_CHAN_FAULT = 8'h01;
  localparam logic [7:0] ADDR_DIAG_CH12 = 8'h02;
  localparam logic [7:0] ADDR_DIAG_CH34 = 8'h03;
  localparam logic [7:0] ADDR_TEMP_SUPPLY = 8'h04;
  localparam logic [7:0] ADDR_OUT_STATE = 8'h05;
  localparam logic [7:0] ADDR_MUTE_PLAY = 8'h06;
  localparam logic [7:0] ADDR_DIAG_ACT = 8'h07;
  localparam logic [7:0] ADDR_GAIN = 8'h08;
  localparam logic [7:0] ADDR_OC_CTRL = 8'h09;
  localparam logic [7:0] ADDR_SWFREQ = 8'h0A;
  localparam logic [7:0] ADDR_DIAG_MASTER = 8'h0B;
  localparam logic [7:0] ADDR_OUT_CTRL_A = 8'h0C;
  localparam logic [7:0] ADDR_OUT_CTRL_B = 8'h0D;
  localparam logic [7:0] ADDR_DC_THRESH = 8'h10;
  localparam logic [7:0] ADDR_THERM_SD = 8'h13;

  localparam int BIT_PV_OV = 7;
  localparam int BIT_PV_UV = 6;
  localparam int BIT_AN_UV = 5;
  localparam int BIT_CHARGE_PUMP_UNDERVOLT_LATCHED = 4;
  localparam int BIT_OT_SD = 3;
  localparam int BIT_ANY_OC = 2;
  localparam int BIT_ANY_DC = 1;
  localparam int BIT_OT_WARN = 0;
  localparam int POS_DC_CH = 4;
  localparam int POS_OC_CH = 0;
  localparam int POS_WARN_GRADE = 5;
  localparam int POS_LOWLOW = 4;
  localparam int POS_HIZ = 0;

  localparam logic [2:0] GRADE_NONE = 3'h0;
  localparam logic [2:0] GRADE_WARN = 3'h1;
  localparam logic [2:0] GRADE_L1 = 3'h3;
  localparam logic [2:0] GRADE_L2 = 3'h5;
  localparam logic [2:0] GRADE_L3 = 3'h7;

  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_OUT_STATE = 8'h0F;
  localparam logic [7:0] RST_GAIN = 8'hAA;
  localparam logic [7:0] RST_OC_CTRL = 8'hF0;
  localparam logic [7:0] RST_CTRL = 8'h00;

  // per-channel live fault events and state, index 0 is channel 1
  typedef struct packed {
    logic [3:0] dc_offset;
    logic [3:0] overcurrent;
    logic [3:0] open_load;
    logic [3:0] shorted_load;
    logic [3:0] short_to_supply;
    logic [3:0] short_to_ground;
  } afsr_chan_evt_t;

  typedef struct packed {
    logic power_rail_overvolt;
    logic power_rail_undervolt;
    logic analog_rail_undervolt;
    logic charge_pump_undervolt;
    logic overtemp_shutdown;
    logic overtemp_warning;
    logic [2:0] overtemp_warn_grade;
  } afsr_glob_evt_t;

  typedef struct packed {
    logic [3:0] out_p_low;
    logic [3:0] out_n_low;
    logic [3:0] hiz;
    logic [3:0] mute;
    logic [3:0] play;
    logic [3:0] foldback;
    logic [3:0] diag_mode;
  } afsr_chan_state_t;

  typedef struct packed {
    logic [7:0] gain;
    logic [7:0] oc_ctrl;
    logic [7:0] swfreq;
    logic [7:0] diag_master;
    logic [7:0] out_ctrl_a;
    logic [7:0] out_ctrl_b;
    logic [7:0] dc_thresh;
  } afsr_ctrl_t;
endpackage : afsr_pkg

// ==== rtl/afsr_latch8.sv ====
`timescale 1ns/1ps
module afsr_latch8 (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_set,
  input wire logic i_clear,
  output logic [7:0] o_q
);
  import afsr_pkg::*;
  // sticky bits; a set in the clearing cycle survives the clear
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_q <= RST_ZERO;
    end else if (i_clear) begin
      o_q <= i_set;
    end else begin
      o_q <= o_q | i_set;
    end
  end
endmodule : afsr_latch8

// ==== verification/afsr_regs_monitor.sv ====
`timescale 1ns/1ps
module afsr_regs_monitor (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire afsr_pkg::afsr_glob_evt_t i_glob,
  input wire afsr_pkg::afsr_chan_evt_t i_chan,
  input wire afsr_pkg::afsr_chan_state_t i_state,
  input wire logic i_fault_clear,
  input wire logic i_sub_load,
  input wire logic [7:0] i_sub_addr,
  input wire logic i_wr_byte,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_byte,
  input wire logic [7:0] o_rd_data,
  input wire logic [7:0] o_sub_addr,
  input wire afsr_pkg::afsr_ctrl_t o_ctrl
);
  import afsr_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  logic idle;
  assign idle = !i_sub_load && !i_wr_byte && !i_rd_byte;
  ptr_load_a: assert property (i_sub_load |=> o_sub_addr == $past(i_sub_addr))
    else $error("pointer not loaded");
  ptr_wr_a: assert property ((i_wr_byte && !i_sub_load)
    |=> o_sub_addr == $past(o_sub_addr) + 8'h01) else $error("no step on write");
  ptr_rd_a: assert property ((i_rd_byte && !i_sub_load && !i_wr_byte)
    |=> o_sub_addr == $past(o_sub_addr) + 8'h01) else $error("no step on read");
  ptr_hold_a: assert property (idle |=> $stable(o_sub_addr))
    else $error("pointer moved while idle");
  gain_write_a: assert property ((i_wr_byte && !i_sub_load &&
    o_sub_addr == ADDR_GAIN) |=> o_ctrl.gain == $past(i_wr_data))
    else $error("gain write lost");
  ro_write_a: assert property ((i_wr_byte && !(o_sub_addr inside
    {[8'h08:8'h0D], 8'h10})) |=> $stable(o_ctrl)) else $error("ro write took");
  unused_zero_a: assert property ((idle && o_sub_addr == 8'h0E)[*3]
    |-> o_rd_data == 8'h00) else $error("unused address not zero");
  gain_read_a: assert property ((idle && o_sub_addr == ADDR_GAIN)[*3]
    |-> o_rd_data == o_ctrl.gain) else $error("gain read mismatch");
  ctrl_reset_a: assert property ($rose(i_arst_n) |-> o_ctrl.gain == 8'hAA
    && o_ctrl.oc_ctrl == 8'hF0) else $error("control reset value wrong");
endmodule : afsr_regs_monitor
bind afsr_regs afsr_regs_monitor u_afsr_regs_monitor (.i_mclk, .i_arst_n,
  .i_glob, .i_chan, .i_state, .i_fault_clear, .i_sub_load, .i_sub_addr,
  .i_wr_byte, .i_wr_data, .i_rd_byte, .o_rd_data, .o_sub_addr, .o_ctrl);

// ==== verification/afsr_host_model.sv ====
`timescale 1ns/1ps
module afsr_host_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_rd_data,
  output logic o_sub_load,
  output logic [7:0] o_sub_addr,
  output logic o_wr_byte,
  output logic [7:0] o_wr_data,
  output logic o_rd_byte
);
  initial begin
    o_sub_load = 1'b0;
    o_sub_addr = 8'h00;
    o_wr_byte = 1'b0;
    o_wr_data = 8'h00;
    o_rd_byte = 1'b0;
  end
  // released data lines show the inverse so stale values never match
  task automatic load(input logic [7:0] a);
    o_sub_addr = a;
    o_sub_load = 1'b1;
    @(posedge i_mclk) #1;
    o_sub_load = 1'b0;
    o_sub_addr = ~a;
  endtask : load
  // an idle edge after each byte, so back-to-back calls never lower
  // and raise the strobe in one time step
  task automatic put(input logic [7:0] d);
    o_wr_data = d;
    o_wr_byte = 1'b1;
    @(posedge i_mclk) #1;
    o_wr_byte = 1'b0;
    o_wr_data = ~d;
    @(posedge i_mclk) #1;
  endtask : put
  // read data lags the pointer by one edge, so three is ample
  task automatic get(output logic [7:0] d);
    repeat (3) @(posedge i_mclk);
    #1;
    d = i_rd_data;
    o_rd_byte = 1'b1;
    @(posedge i_mclk) #1;
    o_rd_byte = 1'b0;
  endtask : get
endmodule : afsr_host_model

// ==== verification/afsr_regs_bench.sv ====
`timescale 1ns/1ps
module afsr_regs_bench;
  import afsr_pkg::*;
  logic i_mclk, i_arst_n, i_fault_clear, sub_load, wr_byte, rd_byte;
  afsr_glob_evt_t i_glob;
  afsr_chan_evt_t i_chan;
  afsr_chan_state_t i_state;
  afsr_ctrl_t ctrl;
  logic [7:0] sub_addr, wr_data, rd_data, ptr, v;
  logic [7:0] exp [0:19];
  logic [2:0] grades [0:4];
  int fails, checks;
  afsr_regs u_afsr_regs (.i_mclk, .i_arst_n, .i_glob, .i_chan, .i_state,
    .i_fault_clear, .i_sub_load(sub_load), .i_sub_addr(sub_addr),
    .i_wr_byte(wr_byte), .i_wr_data(wr_data), .i_rd_byte(rd_byte),
    .o_rd_data(rd_data), .o_sub_addr(ptr), .o_ctrl(ctrl));
  afsr_host_model u_afsr_host_model (.i_mclk, .i_rd_data(rd_data),
    .o_sub_load(sub_load), .o_sub_addr(sub_addr), .o_wr_byte(wr_byte),
    .o_wr_data(wr_data), .o_rd_byte(rd_byte));
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_afsr_host_model.load(a);
    u_afsr_host_model.get(v);
    chk($sformatf("reg %h", a), e, v);
  endtask : rd
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : step
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  initial begin
    #200000;
    fails++;
    end_of_test;
  end
  initial begin
    i_arst_n = 1'b0;
    i_fault_clear = 1'b0;
    i_glob = '0;
    i_chan = '0;
    i_state = '0;
    i_state.hiz = 4'hF;
    grades = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
    exp = '{default: 8'h00};
    exp[5] = 8'h0F;
    exp[8] = 8'hAA;
    exp[9] = 8'hF0;
    step(10);
    i_arst_n = 1'b1;
    step(3);
    // one sequential read walks the whole map, gaps included
    u_afsr_host_model.load(8'h00);
    for (int i = 0; i < 20; i++) begin
      u_afsr_host_model.get(v);
      chk($sformatf("scan %h", i), exp[i], v);
    end
    chk("ptr", 8'h14, ptr);
    u_afsr_host_model.load(ADDR_GAIN);
    for (int i = 0; i < 8; i++) u_afsr_host_model.put(8'(8'h11 * (i + 1)));
    u_afsr_host_model.put(8'h99);
    chk("gain", 8'h11, ctrl.gain);
    chk("oc", 8'h22, ctrl.oc_ctrl);
    chk("diag", 8'h44, ctrl.diag_master);
    chk("out_a", 8'h55, ctrl.out_ctrl_a);
    chk("out_b", 8'h66, ctrl.out_ctrl_b);
    chk("thresh", 8'h99, ctrl.dc_thresh);
    rd(8'h0A, 8'h33);
    rd(8'h0F, 8'h00);
    u_afsr_host_model.load(8'h00);
    u_afsr_host_model.put(8'hFF);
    u_afsr_host_model.put(8'hFF);
    rd(8'h01, 8'h00);
    i_glob.power_rail_overvolt = 1'b1;
    i_glob.charge_pump_undervolt = 1'b1;
    i_glob.overtemp_shutdown = 1'b1;
    i_glob.overtemp_warning = 1'b1;
    i_glob.overtemp_warn_grade = GRADE_L1;
    i_chan = {4'h4, 4'h1, 4'h1, 4'h2, 4'h4, 4'h8};
    step(8);
    rd(8'h04, 8'h79);
    i_glob = '0;
    i_chan = '0;
    step(8);
    rd(8'h00, 8'h9F);
    rd(8'h01, 8'h41);
    rd(8'h02, 8'h48);
    rd(8'h03, 8'h12);
    rd(8'h04, 8'h00);
    i_fault_clear = 1'b1;
    step(1);
    i_fault_clear = 1'b0;
    rd(8'h00, 8'h00);
    rd(8'h02, 8'h00);
    i_chan.overcurrent = 4'h1;
    step(8);
    i_fault_clear = 1'b1;
    step(1);
    i_fault_clear = 1'b0;
    i_chan = '0;
    rd(8'h01, 8'h01);
    foreach (grades[i]) begin
      i_glob.overtemp_warn_grade = grades[i];
      step(6);
      rd(8'h04, {grades[i], 5'h00});
    end
    i_state.out_p_low = 4'h3;
    i_state.out_n_low = 4'h5;
    step(6);
    rd(8'h05, 8'h0F);
    i_state.hiz = 4'h0;
    i_state.mute = 4'hA;
    i_state.play = 4'h5;
    i_state.foldback = 4'h3;
    i_state.diag_mode = 4'hC;
    i_glob.overtemp_shutdown = 1'b1;
    step(6);
    rd(8'h05, 8'h10);
    rd(8'h06, 8'hA5);
    rd(8'h07, 8'h3C);
    rd(8'h13, 8'h13);
    end_of_test;
  end
endmodule : afsr_regs_bench
